// file: src/adrs_sequencer.sv
// Diagnostic result sequencer top level
// Summary of operation
// - Offset beyond two volts is reported as high-offset fault.
// - Offset window opens at last read or offset enable, closes at read.
// - Short, open-load and offset results reported only if condition persists whole period.
// - Short-circuit protection in period suppresses offset and AC tests.
// - AC test runs only while second byte bit D2 is one.
// - Second byte bit D7 picks high or low AC current levels.
// - Tweeter confirmed on three pulses above level, else open reported.
// - Several faults: highest reported first, masked ones on later reads; both shorts report together.
// - Short to ground beats shorted and open load; supply beats both.
// - Short with speaker disconnected reports the short only; the open load is masked.
// - Permanent diagnostics ignore open load; turn-on cycle reports it.
// - Every diagnostic cycle re-arms after each host read.
// - Read returns previous cycle results; change seen on second read.
// - Three thermal warnings appear in diagnostic data.
// - Fast mute bit makes mute transition finish under 1.5 ms.
// - First byte bit D6 enables diagnostics.
// - First byte bit D5 enables offset detection.
`timescale 1ns/10ps
`default_nettype none
`include "adrs_map.svh"
module adrs_sequencer
  #(
  parameter int CHANNELS = 4,
  parameter int FAST_MUTE_CYCLES = `ADRS_FAST_MUTE_US * `ADRS_CLK_MHZ - 1
  )
  (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic ib1_wr_i,
  input wire logic [7:0] first_instruction_byte_i,
  input wire logic ib2_wr_i,
  input wire logic [7:0] second_instruction_byte_i,
  input wire logic host_read_i,
  input wire logic turn_on_cycle_i,
  input wire logic [CHANNELS-1:0] short_gnd_i,
  input wire logic [CHANNELS-1:0] short_vs_i,
  input wire logic [CHANNELS-1:0] short_load_i,
  input wire logic [CHANNELS-1:0] open_load_i,
  input wire logic [CHANNELS-1:0] offset_mv_over_i,
  input wire logic [CHANNELS-1:0] scp_active_i,
  input wire logic [CHANNELS-1:0] peak_normal_hi_i,
  input wire logic [CHANNELS-1:0] peak_normal_lo_i,
  input wire logic [2:0] thermal_warn_i,
  input wire logic mute_req_i,
  output logic [CHANNELS-1:0] res_sgnd_o,
  output logic [CHANNELS-1:0] res_svs_o,
  output logic [CHANNELS-1:0] res_sload_o,
  output logic [CHANNELS-1:0] res_open_o,
  output logic [CHANNELS-1:0] res_offset_o,
  output logic [CHANNELS-1:0] res_tweeter_open_o,
  output logic [2:0] res_thermal_o,
  output logic diag_en_o,
  output logic ac_low_th_o,
  output logic mute_done_o,
  output logic fast_mute_o
  );
  import adrs_pkg::*;
  generate
    if (CHANNELS < 1 || FAST_MUTE_CYCLES < 1)
    begin : gen_bad_param
      $error("adrs_sequencer: bad parameter");
    end
  endgenerate
  // --------------------------------------------------
  // Instruction bytes
  // --------------------------------------------------
  logic [7:0] ib1;
  logic [7:0] ib2;
  logic offs_start;
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      ib1 <= `ADRS_IB_RESET;
    else if (ib1_wr_i)
      ib1 <= first_instruction_byte_i;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      ib2 <= `ADRS_IB_RESET;
    else if (ib2_wr_i)
      ib2 <= second_instruction_byte_i;
  end
  wire logic diag_en = ib1[`ADRS_IB1_DIAG_EN_BIT];
  wire logic offs_en = ib1[`ADRS_IB1_OFFS_EN_BIT];
  wire logic ac_en = ib2[`ADRS_IB2_AC_EN_BIT];
  wire logic low_th = ib2[`ADRS_IB2_LOWTH_BIT];
  wire logic fast_mute = ib2[`ADRS_IB2_FASTMUTE_BIT];
  // Offset window restarts on read or on a 0-to-1 write of offset enable
  assign offs_start = host_read_i |
    (ib1_wr_i & first_instruction_byte_i[`ADRS_IB1_OFFS_EN_BIT] & ~offs_en);
  // AC measuring period restarts on read or on AC enable rising
  wire logic ac_start = host_read_i |
    (ib2_wr_i & second_instruction_byte_i[`ADRS_IB2_AC_EN_BIT] & ~ac_en);
  // --------------------------------------------------
  // Per-channel accumulators
  // --------------------------------------------------
  logic [CHANNELS-1:0] p_gnd, p_vs, p_load, p_open, p_offs;
  logic [CHANNELS-1:0] scp_seen;
  logic [CHANNELS-1:0] pulse_ok;
  adrs_fault_t [CHANNELS-1:0] prio;
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : gen_ch
      logic [1:0] pulse_cnt;
      logic pk_d;
      wire logic pk = low_th ? peak_normal_lo_i[g] : peak_normal_hi_i[g];
      adrs_persist u_gnd (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .restart_i(host_read_i),
        .cond_i(short_gnd_i[g]), .held_o(p_gnd[g]));
      adrs_persist u_vs (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .restart_i(host_read_i),
        .cond_i(short_vs_i[g]), .held_o(p_vs[g]));
      adrs_persist u_load (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .restart_i(host_read_i),
        .cond_i(short_load_i[g]), .held_o(p_load[g]));
      adrs_persist u_open (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .restart_i(host_read_i),
        .cond_i(open_load_i[g] & turn_on_cycle_i), .held_o(p_open[g]));
      adrs_persist u_offs (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .restart_i(offs_start),
        .cond_i(offset_mv_over_i[g]), .held_o(p_offs[g]));
      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          scp_seen[g] <= 1'b0;
        else if (host_read_i)
          scp_seen[g] <= scp_active_i[g];
        else
          scp_seen[g] <= scp_seen[g] | scp_active_i[g];
      end
      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          pk_d <= 1'b0;
        else
          pk_d <= pk;
      end
      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          pulse_cnt <= 2'h0;
        else if (ac_start || !ac_en)
          pulse_cnt <= 2'h0;
        else if (pk && !pk_d && pulse_cnt != 2'(`ADRS_AC_MIN_PULSES))
          pulse_cnt <= pulse_cnt + 2'h1;
      end
      assign pulse_ok[g] = (pulse_cnt == 2'(`ADRS_AC_MIN_PULSES));
      // Pair priorities: shorts mask load faults, both shorts report together
      always_comb
      begin
        prio[g].sgnd = p_gnd[g];
        prio[g].svs = p_vs[g];
        prio[g].sacross = p_load[g] & ~p_gnd[g] & ~p_vs[g];
        prio[g].open = p_open[g] & ~p_gnd[g] & ~p_vs[g] & ~p_load[g];
      end
    end
  endgenerate
  // --------------------------------------------------
  // Result latch at read
  // --------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      res_sgnd_o <= '0;
      res_svs_o <= '0;
      res_sload_o <= '0;
      res_open_o <= '0;
      res_offset_o <= '0;
      res_tweeter_open_o <= '0;
      res_thermal_o <= 3'h0;
    end
    else if (host_read_i)
    begin
      // Masked faults are not stored; they show on a later read only if still held once the shorts clear
      for (int i = 0; i < CHANNELS; i++)
      begin
        res_sgnd_o[i] <= prio[i].sgnd & diag_en;
        res_svs_o[i] <= prio[i].svs & diag_en;
        res_sload_o[i] <= prio[i].sacross & diag_en;
        res_open_o[i] <= prio[i].open & diag_en;
        res_offset_o[i] <= p_offs[i] & offs_en & ~scp_seen[i] & diag_en;
        res_tweeter_open_o[i] <= ac_en & ~pulse_ok[i] & ~scp_seen[i] & diag_en;
      end
      res_thermal_o <= thermal_warn_i;
    end
  end
  // --------------------------------------------------
  // Mute timing
  // --------------------------------------------------
  adrs_mute_t mute_st;
  logic [$clog2(FAST_MUTE_CYCLES+1)-1:0] mute_cnt;
  logic mute_d;
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      mute_d <= 1'b0;
    else
      mute_d <= mute_req_i;
  end
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mute_st <= ADRS_ST_IDLE;
      mute_cnt <= '0;
    end
    else
    begin
      unique case (mute_st)
        ADRS_ST_IDLE:
        begin
          mute_cnt <= '0;
          if (mute_req_i && !mute_d)
            mute_st <= fast_mute ? ADRS_ST_FAST : ADRS_ST_NORMAL;
        end
        ADRS_ST_FAST:
        begin
          mute_cnt <= mute_cnt + ($bits(mute_cnt))'(1);
          if (mute_cnt == ($bits(mute_cnt))'(FAST_MUTE_CYCLES - 1))
            mute_st <= ADRS_ST_IDLE;
        end
        ADRS_ST_NORMAL:
        begin
          if (!mute_req_i || fast_mute)
            mute_st <= fast_mute ? ADRS_ST_FAST : ADRS_ST_IDLE;
        end
      endcase
    end
  end
  assign mute_done_o = (mute_st == ADRS_ST_FAST) &&
    (mute_cnt == ($bits(mute_cnt))'(FAST_MUTE_CYCLES - 1));
  assign diag_en_o = diag_en;
  assign ac_low_th_o = low_th;
  assign fast_mute_o = fast_mute;
endmodule // adrs_sequencer
`default_nettype wire

// file: src/adrs_map.svh
// Constant map for the amplifier diagnostic result sequencer
`ifndef ADRS_MAP_SVH
`define ADRS_MAP_SVH
`define ADRS_IB1_DIAG_EN_BIT 6
`define ADRS_IB1_OFFS_EN_BIT 5
`define ADRS_IB2_LOWTH_BIT 7
`define ADRS_IB2_FASTMUTE_BIT 5
`define ADRS_IB2_AC_EN_BIT 2
`define ADRS_IB_RESET 8'h00
`define ADRS_OFFSET_LIMIT_MV 2000
`define ADRS_AC_MIN_PULSES 3
`define ADRS_FAST_MUTE_US 1500
`define ADRS_CLK_MHZ 100
`define ADRS_NORM_HI_MA 500
`define ADRS_OPEN_HI_MA 250
`define ADRS_NORM_LO_MA 250
`define ADRS_OPEN_LO_MA 125
`endif

// file: src/adrs_pkg.sv
// Types for the amplifier diagnostic result sequencer
package adrs_pkg;
  typedef enum logic [1:0] {ADRS_ST_IDLE, ADRS_ST_FAST, ADRS_ST_NORMAL} adrs_mute_t;
  typedef struct packed {
    logic sgnd;
    logic svs;
    logic sacross;
    logic open;
  } adrs_fault_t;
endpackage

// file: src/adrs_persist.sv
// Per-channel persistence tracker over one measurement period
`timescale 1ns/10ps
`default_nettype none
module adrs_persist
  (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic restart_i,
  input wire logic cond_i,
  output logic held_o
  );
  // --------------------------------------------------
  // Persistence
  // --------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      held_o <= 1'b0;
    else if (restart_i)
      held_o <= cond_i;
    else
      held_o <= held_o & cond_i;
  end
endmodule // adrs_persist
`default_nettype wire

// file: tb/adrs_sequencer_properties.sv
// Checker for the diagnostic result sequencer ports
`timescale 1ns/10ps
`default_nettype none
module adrs_sequencer_properties
  #(parameter int CHANNELS = 4, parameter int FAST_MUTE_CYCLES = 149999)
  (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic host_read_i,
  input wire logic turn_on_cycle_i,
  input wire logic [CHANNELS-1:0] short_gnd_i,
  input wire logic [CHANNELS-1:0] scp_active_i,
  input wire logic [2:0] thermal_warn_i,
  input wire logic mute_req_i,
  input wire logic [CHANNELS-1:0] res_sgnd_o,
  input wire logic [CHANNELS-1:0] res_svs_o,
  input wire logic [CHANNELS-1:0] res_sload_o,
  input wire logic [CHANNELS-1:0] res_open_o,
  input wire logic [CHANNELS-1:0] res_offset_o,
  input wire logic [CHANNELS-1:0] res_tweeter_open_o,
  input wire logic [2:0] res_thermal_o,
  input wire logic diag_en_o,
  input wire logic mute_done_o,
  input wire logic fast_mute_o
  );
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  int mcnt;
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i) mcnt <= 0;
    else if (mute_done_o) mcnt <= 0;
    else if (mcnt != 0 || ($rose(mute_req_i) && fast_mute_o)) mcnt <= mcnt + 1;
  property p_hold;
    !host_read_i |=> $stable(res_sgnd_o) && $stable(res_offset_o);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved without read");
  property p_off;
    host_read_i && !diag_en_o |=> res_sgnd_o == '0 && res_svs_o == '0;
  endproperty
  a_off: assert property (p_off) else $error("fault while disabled");
  property p_gnd;
    host_read_i |=> (res_sgnd_o & ~$past(short_gnd_i, 2)) == '0;
  endproperty
  a_gnd: assert property (p_gnd) else $error("fault not held");
  property p_sload;
    (res_sload_o & (res_sgnd_o | res_svs_o)) == '0;
  endproperty
  a_sload: assert property (p_sload) else $error("load short not masked");
  property p_perm;
    host_read_i && !$past(turn_on_cycle_i) |=> res_open_o == '0;
  endproperty
  a_perm: assert property (p_perm) else $error("open outside turn-on");
  property p_scp;
    host_read_i |=> ((res_offset_o | res_tweeter_open_o) & $past(scp_active_i, 2)) == '0;
  endproperty
  a_scp: assert property (p_scp) else $error("test not suppressed");
  property p_therm;
    host_read_i |=> res_thermal_o == $past(thermal_warn_i);
  endproperty
  a_therm: assert property (p_therm) else $error("thermal not latched");
  property p_mute;
    mcnt <= FAST_MUTE_CYCLES + 2;
  endproperty
  a_mute: assert property (p_mute) else $error("fast mute too slow");
endmodule // adrs_sequencer_properties
bind adrs_sequencer adrs_sequencer_properties
  #(.CHANNELS(CHANNELS), .FAST_MUTE_CYCLES(FAST_MUTE_CYCLES)) chk_u (.*);
`default_nettype wire

// file: tb/adrs_host_model.sv
// Host controller model writing instruction bytes and reading results
`timescale 1ns/10ps
`default_nettype none
module adrs_host_model
  (
  input wire logic clk_sys_i,
  output logic ib1_wr_o,
  output logic ib2_wr_o,
  output logic [7:0] ib1_o,
  output logic [7:0] ib2_o,
  output logic rd_o
  );
  // ----
  // Transfers
  // ----
  initial {ib1_wr_o, ib2_wr_o, rd_o, ib1_o, ib2_o} = 19'h0;
  task automatic wr(input logic [7:0] b1, input logic [7:0] b2);
    @(negedge clk_sys_i);
    {ib1_o, ib2_o, ib1_wr_o, ib2_wr_o} = {b1, b2, 2'h3};
    @(negedge clk_sys_i);
    {ib1_o, ib2_o, ib1_wr_o, ib2_wr_o} = {~b1, ~b2, 2'h0};
  endtask
  task automatic rd;
    @(negedge clk_sys_i);
    rd_o = 1'b1;
    @(negedge clk_sys_i);
    rd_o = 1'b0;
  endtask
endmodule // adrs_host_model
`default_nettype wire

// file: tb/adrs_sequencer_tb.sv
// Self-checking bench for the diagnostic result sequencer
`timescale 1ns/10ps
`default_nettype none
module adrs_sequencer_tb;
  // ----
  // Bench
  // ----
  logic clk_sys_i = 1'b0, rst_i = 1'b1, turn_on_cycle_i = 1'b0, mute_req_i = 1'b0;
  logic ib1_wr_i, ib2_wr_i, host_read_i;
  logic [7:0] first_instruction_byte_i, second_instruction_byte_i;
  logic [3:0] short_gnd_i = '0, short_vs_i = '0, short_load_i = '0, open_load_i = '0;
  logic [3:0] offset_mv_over_i = '0, scp_active_i = '0;
  logic [3:0] peak_normal_hi_i = '0, peak_normal_lo_i = '0;
  logic [2:0] thermal_warn_i = '0, res_thermal_o;
  logic [3:0] res_sgnd_o, res_svs_o, res_sload_o, res_open_o, res_offset_o, res_tweeter_open_o;
  logic diag_en_o, ac_low_th_o, mute_done_o, fast_mute_o;
  localparam int FAST_CYCLES = 20;
  int errors = 0;
  int checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  adrs_sequencer #(.FAST_MUTE_CYCLES(FAST_CYCLES)) dut_u (.*);
  adrs_host_model host_u (.clk_sys_i, .ib1_wr_o(ib1_wr_i), .ib2_wr_o(ib2_wr_i),
    .ib1_o(first_instruction_byte_i), .ib2_o(second_instruction_byte_i), .rd_o(host_read_i));
  task automatic cmp(input string n, input logic [3:0] e, input logic [3:0] s);
    checks++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rd2;
    host_u.rd();
    host_u.rd();
  endtask
  task automatic pulse(input logic [3:0] h, input logic [3:0] l);
    @(negedge clk_sys_i);
    {peak_normal_hi_i, peak_normal_lo_i} = {h, l};
    @(negedge clk_sys_i);
    {peak_normal_hi_i, peak_normal_lo_i} = 8'h00;
  endtask
  task automatic t_faults;
    {short_gnd_i, short_vs_i, short_load_i, open_load_i} = 16'h3279;
    turn_on_cycle_i = 1'b1;
    host_u.rd();
    cmp("gnd", 4'h0, res_sgnd_o);
    host_u.rd();
    cmp("gnd", 4'h3, res_sgnd_o);
    cmp("vs", 4'h2, res_svs_o);
    cmp("load", 4'h4, res_sload_o);
    cmp("open", 4'h8, res_open_o);
    {short_gnd_i, short_vs_i, turn_on_cycle_i} = 9'h0;
    rd2();
    cmp("load", 4'h7, res_sload_o);
    cmp("open", 4'h0, res_open_o);
  endtask
  task automatic t_offset;
    {short_load_i, open_load_i, offset_mv_over_i} = 12'h003;
    host_u.wr(8'h40, 8'h04);
    host_u.wr(8'h60, 8'h04);
    scp_active_i = 4'h2;
    @(negedge clk_sys_i);
    scp_active_i = 4'h0;
    host_u.rd();
    cmp("offset", 4'h1, res_offset_o);
    host_u.wr(8'h40, 8'h04);
    rd2();
    cmp("offset", 4'h0, res_offset_o);
    offset_mv_over_i = 4'h0;
  endtask
  task automatic t_ac;
    for (int i = 0; i < 2; i++)
    begin
      host_u.wr(8'h60, {i[0], 7'h04});
      cmp("low_th", {3'h0, i[0]}, {3'h0, ac_low_th_o});
      host_u.rd();
      repeat (2) pulse(4'h3, 4'h4);
      pulse(4'h1, 4'h4);
      host_u.rd();
      cmp("tweeter", i ? 4'hb : 4'he, res_tweeter_open_o);
    end
    thermal_warn_i = 3'h5;
    host_u.wr(8'h60, 8'h00);
    rd2();
    cmp("tweeter", 4'h0, res_tweeter_open_o);
    cmp("thermal", 4'h5, {1'b0, res_thermal_o});
  endtask
  task automatic t_mute;
    int n;
    int hits;
    hits = 0;
    mute_req_i = 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge clk_sys_i);
      if (mute_done_o !== 1'b0)
        hits++;
    end
    mute_req_i = 1'b0;
    cmp("mute_normal", 4'h0, {3'h0, hits != 0});
    host_u.wr(8'h60, 8'h20);
    cmp("fast", 4'h1, {3'h0, fast_mute_o});
    mute_req_i = 1'b1;
    for (n = 0; n < 40 && mute_done_o !== 1'b1; n++)
      @(negedge clk_sys_i);
    cmp("mute", 4'h1, {3'h0, mute_done_o});
    cmp("mute_cycles", 4'h1, {3'h0, n <= FAST_CYCLES});
    host_u.wr(8'h00, 8'h00);
    cmp("fast", 4'h0, {3'h0, fast_mute_o});
    mute_req_i = 1'b0;
    short_gnd_i = 4'h1;
    rd2();
    cmp("gnd", 4'h0, res_sgnd_o);
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b0;
    host_u.wr(8'h60, 8'h04);
    cmp("diag", 4'h1, {3'h0, diag_en_o});
    t_faults();
    t_offset();
    t_ac();
    t_mute();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    errors++;
    tally_and_finish();
  end
endmodule // adrs_sequencer_tb
`default_nettype wire
